//--- cev_pkg.sv
// Purpose: shared constants and types for the exception vectoring unit
// Assumes: 20-bit core addresses, 16-bit words, byte addressing
// Notes: vector table sits at the bottom of program and data space
package cev_pkg;
  // ==========================================================
  // widths
  localparam int CEV_AW = 20;
  localparam int CEV_BW = 24;
  localparam int CEV_DW = 16;
  // ==========================================================
  // reset table word addresses (program space)
  localparam logic [19:0] CEV_RST_BANKS = 20'h00000;
  localparam logic [19:0] CEV_RST_PC = 20'h00002;
  localparam logic [19:0] CEV_RST_SP = 20'h00004;
  localparam logic [19:0] CEV_RST_IZ = 20'h00006;
  // ==========================================================
  // vector numbers (data space)
  localparam logic [7:0] CEV_VEC_BKPT = 8'h04;
  localparam logic [7:0] CEV_VEC_BERR = 8'h05;
  localparam logic [7:0] CEV_VEC_SWI = 8'h06;
  localparam logic [7:0] CEV_VEC_ILL = 8'h07;
  localparam logic [7:0] CEV_VEC_DIV0 = 8'h08;
  localparam logic [7:0] CEV_VEC_UNINIT = 8'h0f;
  localparam logic [7:0] CEV_VEC_AUTO0 = 8'h10;
  localparam logic [7:0] CEV_VEC_SPUR = 8'h18;
  localparam logic [7:0] CEV_VEC_USER0 = 8'h38;
  // stacked pc offset beyond next instruction
  localparam logic [19:0] CEV_PC_BIAS = 20'h00006;
  // stack frame step in bytes
  localparam logic [15:0] CEV_SP_STEP = 16'h0002;
  // ==========================================================
  // exception source kinds
  typedef enum logic [3:0] {
    CEV_EX_BKPT = 4'b0000,
    CEV_EX_BERR = 4'b0001,
    CEV_EX_SWI = 4'b0010,
    CEV_EX_ILL = 4'b0011,
    CEV_EX_DIV0 = 4'b0100,
    CEV_EX_UNINIT = 4'b0101,
    CEV_EX_AUTO = 4'b0110,
    CEV_EX_SPUR = 4'b0111,
    CEV_EX_USER = 4'b1000
  } cev_kind_t;
  // exception request from the core
  typedef struct packed {
    cev_kind_t kind;
    logic [2:0] level;
    logic [7:0] user_vec;
    logic [19:0] next_pc;
    logic [15:0] ccr;
  } cev_req_t;
  // memory request
  typedef struct packed {
    logic rd;
    logic wr;
    logic prog;
    logic [23:0] addr;
    logic [15:0] wdata;
  } cev_mem_t;
  // bank extension set
  typedef struct packed {
    logic [3:0] index_z_bank_ext;
    logic [3:0] stack_bank_ext;
    logic [3:0] program_bank_ext;
  } cev_banks_t;
endpackage : cev_pkg

//--- cev_unit.sv
// Purpose: reset fetch, exception vectoring and stacking of the core
// Assumes: memory answers each access with a one-cycle MEM_ACK
// Notes: registers live here only, never on the module bus
`timescale 1ns/1ps
// Function
// - reset fetches banks, pc, sp at 0/2/4
// - reset then loads direct page index from 6
// - autovector levels 1-7 use words 22-2e
// - push pc and ccr at stack bank:sp
// - stacked pc is next instruction plus six
// - linear megabyte of sixteen banks
// - module bus bits 23:20 copy bit 19
// - core registers never memory mapped
// - io uses ordinary load and store
module cev_unit
  import cev_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // exception request from core
  input wire logic EX_VALID,
  input wire cev_pkg::cev_req_t EX_REQ,
  // ordinary core load/store
  input wire logic LS_VALID,
  input wire logic LS_WR,
  input wire logic [19:0] LS_ADDR,
  input wire logic [15:0] LS_WDATA,
  // memory side
  output cev_pkg::cev_mem_t MEM,
  input wire logic MEM_ACK,
  input wire logic [15:0] MEM_RDATA,
  // core state out
  output logic BUSY,
  output logic HANDLER_VALID,
  output logic [19:0] HANDLER_PC,
  output logic [19:0] CORE_PC,
  output logic [15:0] CORE_SP,
  output logic [15:0] CORE_IZ,
  output cev_pkg::cev_banks_t BANKS
);
  import cev_pkg::*;
  // ==========================================================
  // state machine
  typedef enum logic [3:0] {
    CEV_S_RBANK = 4'b0000,
    CEV_S_RPC = 4'b0001,
    CEV_S_RSP = 4'b0010,
    CEV_S_RIZ = 4'b0011,
    CEV_S_IDLE = 4'b0100,
    CEV_S_PUSHPC = 4'b0101,
    CEV_S_PUSHPK = 4'b0110,
    CEV_S_PUSHCC = 4'b0111,
    CEV_S_VEC = 4'b1000,
    CEV_S_LS = 4'b1001
  } cev_state_t;
  cev_state_t state; // current phase
  cev_req_t req; // captured exception
  logic [7:0] vec_num; // resolved vector number
  logic [19:0] stack_addr; // stack bank : sp
  logic [19:0] stacked_pc; // next pc plus bias
  // ==========================================================
  // vector number resolution
  always_comb begin
    case (req.kind)
      CEV_EX_BKPT: vec_num = CEV_VEC_BKPT;
      CEV_EX_BERR: vec_num = CEV_VEC_BERR;
      CEV_EX_SWI: vec_num = CEV_VEC_SWI;
      CEV_EX_ILL: vec_num = CEV_VEC_ILL;
      CEV_EX_DIV0: vec_num = CEV_VEC_DIV0;
      CEV_EX_AUTO: begin
        // level zero is no request; treat as spurious
        if (req.level == 3'h0) begin
          vec_num = CEV_VEC_SPUR;
        end else begin
          vec_num = CEV_VEC_AUTO0 + {5'h00, req.level};
        end
      end
      CEV_EX_SPUR: vec_num = CEV_VEC_SPUR;
      CEV_EX_USER: begin
        // below user range falls back to uninitialized
        if (req.user_vec < CEV_VEC_USER0) begin
          vec_num = CEV_VEC_UNINIT;
        end else begin
          vec_num = req.user_vec;
        end
      end
      default: vec_num = CEV_VEC_UNINIT;
    endcase
  end
  // linear megabyte: bank nibble over 16-bit offset
  assign stack_addr = {BANKS.stack_bank_ext, CORE_SP};
  assign stacked_pc = req.next_pc + CEV_PC_BIAS;
  // ==========================================================
  // sequencing
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state <= CEV_S_RBANK;
    end else begin
      case (state)
        CEV_S_RBANK: if (MEM_ACK) state <= CEV_S_RPC;
        CEV_S_RPC: if (MEM_ACK) state <= CEV_S_RSP;
        CEV_S_RSP: if (MEM_ACK) state <= CEV_S_RIZ;
        CEV_S_RIZ: if (MEM_ACK) state <= CEV_S_IDLE;
        CEV_S_IDLE: begin
          // exceptions win over loads and stores
          if (EX_VALID) begin
            state <= CEV_S_PUSHPC;
          end else if (LS_VALID) begin
            state <= CEV_S_LS;
          end
        end
        CEV_S_PUSHPC: if (MEM_ACK) state <= CEV_S_PUSHPK;
        CEV_S_PUSHPK: if (MEM_ACK) state <= CEV_S_PUSHCC;
        CEV_S_PUSHCC: if (MEM_ACK) state <= CEV_S_VEC;
        CEV_S_VEC: if (MEM_ACK) state <= CEV_S_IDLE;
        CEV_S_LS: if (MEM_ACK) state <= CEV_S_IDLE;
        default: state <= CEV_S_IDLE;
      endcase
    end
  end
  // ==========================================================
  // exception capture
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      req <= '0;
    end else if (state == CEV_S_IDLE && EX_VALID) begin
      req <= EX_REQ;
    end
  end
  // ==========================================================
  // core registers: internal only, loaded from reset table
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      BANKS <= '0;
      CORE_PC <= '0;
      CORE_SP <= '0;
      CORE_IZ <= '0;
    end else if (MEM_ACK) begin
      case (state)
        CEV_S_RBANK: begin
          // word layout: zk 11:8, sk 7:4, pk 3:0
          BANKS.index_z_bank_ext <= MEM_RDATA[11:8];
          BANKS.stack_bank_ext <= MEM_RDATA[7:4];
          BANKS.program_bank_ext <= MEM_RDATA[3:0];
        end
        CEV_S_RPC: CORE_PC <= {BANKS.program_bank_ext, MEM_RDATA};
        CEV_S_RSP: CORE_SP <= MEM_RDATA;
        CEV_S_RIZ: CORE_IZ <= MEM_RDATA;
        CEV_S_PUSHPC, CEV_S_PUSHPK, CEV_S_PUSHCC: begin
          // post-decrement stack: write at sp, then sp drops one word per push
          CORE_SP <= CORE_SP - CEV_SP_STEP;
        end
        CEV_S_VEC: begin
          // handler in bank zero for the vector fetch
          CORE_PC <= {4'h0, MEM_RDATA};
          BANKS.program_bank_ext <= 4'h0;
        end
        default: CORE_PC <= CORE_PC;
      endcase
    end
  end
  // ==========================================================
  // memory request, registered; addr 23:20 copy bit 19
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      MEM <= '0;
    end else begin
      MEM.rd <= 1'b0;
      MEM.wr <= 1'b0;
      MEM.prog <= 1'b0;
      MEM.wdata <= '0;
      MEM.addr <= '0;
      if (!MEM_ACK || state == CEV_S_IDLE) begin
        case (state)
          CEV_S_RBANK: begin
            MEM.rd <= 1'b1;
            MEM.prog <= 1'b1;
            MEM.addr <= {{4{CEV_RST_BANKS[19]}}, CEV_RST_BANKS};
          end
          CEV_S_RPC: begin
            MEM.rd <= 1'b1;
            MEM.prog <= 1'b1;
            MEM.addr <= {{4{CEV_RST_PC[19]}}, CEV_RST_PC};
          end
          CEV_S_RSP: begin
            MEM.rd <= 1'b1;
            MEM.prog <= 1'b1;
            MEM.addr <= {{4{CEV_RST_SP[19]}}, CEV_RST_SP};
          end
          CEV_S_RIZ: begin
            MEM.rd <= 1'b1;
            MEM.prog <= 1'b1;
            MEM.addr <= {{4{CEV_RST_IZ[19]}}, CEV_RST_IZ};
          end
          CEV_S_PUSHPC, CEV_S_PUSHPK, CEV_S_PUSHCC: begin
            MEM.wr <= 1'b1;
            MEM.addr <= {{4{stack_addr[19]}}, stack_addr};
            if (state == CEV_S_PUSHPC) begin
              MEM.wdata <= stacked_pc[15:0];
            end else if (state == CEV_S_PUSHPK) begin
              MEM.wdata <= {12'h000, stacked_pc[19:16]};
            end else begin
              MEM.wdata <= req.ccr;
            end
          end
          CEV_S_VEC: begin
            MEM.rd <= 1'b1;
            MEM.addr <= {15'h0000, vec_num, 1'b0};
          end
          CEV_S_LS: begin
            MEM.rd <= !LS_WR;
            MEM.wr <= LS_WR;
            MEM.addr <= {{4{LS_ADDR[19]}}, LS_ADDR};
            MEM.wdata <= LS_WDATA;
          end
          default: MEM.addr <= '0;
        endcase
      end
    end
  end
  // ==========================================================
  // status outputs
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      BUSY <= 1'b1;
      HANDLER_VALID <= 1'b0;
      HANDLER_PC <= '0;
    end else begin
      BUSY <= !(state == CEV_S_IDLE && !EX_VALID && !LS_VALID);
      HANDLER_VALID <= (state == CEV_S_VEC) && MEM_ACK;
      if (state == CEV_S_VEC && MEM_ACK) begin
        HANDLER_PC <= {4'h0, MEM_RDATA};
      end
    end
  end
endmodule // cev_unit

//--- cev_unit_monitor.sv
// Purpose: port assertions for the vectoring unit
// Assumes: one clock, sync active-high reset
// Notes: bound to every cev_unit
`timescale 1ns/1ps
module cev_unit_monitor (
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // memory side
  input wire cev_pkg::cev_mem_t MEM,
  input wire logic MEM_ACK,
  input wire logic [15:0] MEM_RDATA,
  // handler
  input wire logic HANDLER_VALID,
  input wire logic [19:0] HANDLER_PC
);
  import cev_pkg::*;
  // ==========================================
  // shared terms
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  logic act; // access underway
  logic prd; // program-space read
  logic [23:0] a; // bus address
  logic prd_data; // data-space read
  logic a_odd; // odd byte address
  assign act = MEM.rd | MEM.wr;
  assign prd = MEM.rd & MEM.prog;
  assign a = MEM.addr;
  assign prd_data = MEM.rd & ~MEM.prog;
  assign a_odd = MEM.addr[0];
  // ==========================================
  // assertions
  a_bus_ext: assert property (act |-> a[23:20] == {4{a[19]}})
    else $error("bad bus top bits");
  a_rst_first: assert property ($fell(SYS_RST) |-> ##[0:1] prd && a == 24'h0)
    else $error("reset fetch not at word 0");
  a_rst_pc: assert property (prd && MEM_ACK && a == 24'h0 |-> ##[1:3] prd && a == 24'h2)
    else $error("pc word not after bank word");
  a_rst_sp: assert property (prd && MEM_ACK && a == 24'h2 |-> ##[1:3] prd && a == 24'h4)
    else $error("sp word not after pc word");
  a_rst_iz: assert property (prd && MEM_ACK && a == 24'h4 |-> ##[1:3] prd && a == 24'h6)
    else $error("index word not after sp word");
  a_hv_src: assert property (HANDLER_VALID |-> $past(prd_data) && $past(MEM_ACK))
    else $error("handler without data read");
  a_hv_data: assert property (HANDLER_VALID |-> HANDLER_PC == {4'h0, $past(MEM_RDATA)})
    else $error("handler not vector word");
  a_vec_addr: assert property (HANDLER_VALID |-> $past(a) < 24'h200 && !$past(a_odd))
    else $error("vector outside table");
  a_mem_stand: assert property (act && !MEM_ACK |=> $stable(MEM))
    else $error("request moved before answer");
  c_hv: cover property (HANDLER_VALID);
  c_push: cover property (MEM.wr && MEM_ACK);
  c_high: cover property (act && a[19]);
endmodule // cev_unit_monitor
bind cev_unit cev_unit_monitor i_mon (.CLK(CLK), .SYS_RST(SYS_RST), .MEM(MEM),
  .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .HANDLER_VALID(HANDLER_VALID),
  .HANDLER_PC(HANDLER_PC));

//--- cev_mem_model.sv
// Purpose: memory holding vector table and stack
// Assumes: word content is key xor address
// Notes: one idle cycle follows each answer
`timescale 1ns/1ps
module cev_mem_model (
  // clock
  input wire logic clk,
  // request and answer
  input wire cev_pkg::cev_mem_t mem,
  input wire logic slow,
  input wire logic [15:0] key,
  output logic ack,
  output logic [15:0] rdata
);
  import cev_pkg::*;
  logic gap = 1'b0; // request just answered
  logic [1:0] cnt = 2'h0; // latency left
  initial ack = 1'b0;
  initial rdata = 16'h0;
  // ==========================================
  // answer after zero or three wait cycles
  always @(posedge clk) begin
    ack <= 1'b0;
    rdata <= ~rdata; // no stale data between answers
    gap <= 1'b0;
    if (gap) begin
      cnt <= slow ? 2'h3 : 2'h0;
    end else if ((mem.rd | mem.wr) && cnt != 2'h0) begin
      cnt <= cnt - 2'h1;
    end else if (mem.rd | mem.wr) begin
      ack <= 1'b1;
      gap <= 1'b1;
      rdata <= key ^ mem.addr[15:0];
    end
  end
endmodule // cev_mem_model

//--- cev_tb.sv
// Purpose: self-checking bench for the vectoring unit
// Assumes: memory model answers every access
// Notes: observed accesses and handler pulses kept in queues
`timescale 1ns/1ps
module testbench;
  import cev_pkg::*;
  logic clk = 0, sys_rst = 1, ex_valid = 0, ls_valid = 0, ls_wr = 0, slow = 0;
  logic [19:0] ls_addr = 0, hpc, pc;
  logic [15:0] ls_wdata = 0, key = 0, rdata, sp, iz, e_sp;
  logic ack, busy, hv;
  logic [3:0] sk;
  cev_req_t ex_req = '0;
  cev_mem_t mem;
  cev_banks_t banks;
  int err_total = 0, check_count = 0, seed = 11526;
  cev_mem_t seen[$];
  logic [19:0] hv_q[$];
  logic [7:0] vt [8] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0f, 8'h18, 8'h18};
  always #5 clk = ~clk;
  cev_unit i_dut (.CLK(clk), .SYS_RST(sys_rst), .EX_VALID(ex_valid), .EX_REQ(ex_req),
    .LS_VALID(ls_valid), .LS_WR(ls_wr), .LS_ADDR(ls_addr), .LS_WDATA(ls_wdata),
    .MEM(mem), .MEM_ACK(ack), .MEM_RDATA(rdata), .BUSY(busy), .HANDLER_VALID(hv),
    .HANDLER_PC(hpc), .CORE_PC(pc), .CORE_SP(sp), .CORE_IZ(iz), .BANKS(banks));
  cev_mem_model i_mem (.clk(clk), .mem(mem), .slow(slow), .key(key), .ack(ack),
    .rdata(rdata));
  // ==========================================
  // record answered accesses and handler pulses
  always @(posedge clk) begin
    if (ack === 1'b1) seen.push_back(mem);
    if (hv === 1'b1) hv_q.push_back(hpc);
  end
  task automatic chk(string nm, logic [47:0] e, logic [47:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic acc(string nm, logic [2:0] k, logic [19:0] a, logic [15:0] w, logic [15:0] m);
    cev_mem_t g;
    g = seen.size() ? seen.pop_front() : 'x;
    chk(nm, {k, {4{a[19]}}, a, w & m}, {g.rd, g.wr, g.prog, g.addr, g.wdata & m});
  endtask
  task automatic idle();
    int n;
    n = 0;
    @(posedge clk);
    while (busy !== 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) chk("busy", 0, 1);
    #1;
  endtask
  task automatic rst(int n);
    key = 16'($random(seed));
    sys_rst = 1'b1;
    repeat (n) @(posedge clk);
    seen.delete();
    #1 sys_rst = 1'b0;
    idle();
    for (int i = 0; i < 4; i++) acc("rst", 3'b101, 20'(2 * i), 16'h0, 16'h0);
    chk("banks", key[11:0], banks);
    chk("pc", {key[3:0], key ^ 16'h2}, pc);
    chk("sp", key ^ 16'h4, sp);
    chk("iz", key ^ 16'h6, iz);
    sk = key[7:4];
    e_sp = key ^ 16'h4;
  endtask
  task automatic ex(cev_kind_t k, logic [2:0] lv, logic [7:0] uv, logic [7:0] vn);
    logic [19:0] npc;
    logic [15:0] c;
    npc = 20'($random(seed));
    c = 16'($random(seed));
    slow = 1'($random(seed));
    hv_q.delete();
    ex_req = {k, lv, uv, npc, c};
    ex_valid = 1'b1;
    @(posedge clk);
    #1 ex_valid = 1'b0;
    idle();
    npc = npc + 20'h6;
    acc("pc_lo", 3'b010, {sk, e_sp}, npc[15:0], 16'hffff);
    acc("pc_hi", 3'b010, {sk, e_sp - 16'h2}, {12'h0, npc[19:16]}, 16'h000f);
    acc("ccr", 3'b010, {sk, e_sp - 16'h4}, c, 16'hffff);
    acc("vec", 3'b100, {11'h0, vn, 1'b0}, 16'h0, 16'h0);
    e_sp = e_sp - 16'h6;
    chk("sp", e_sp, sp);
    chk("hpc", {4'h0, key ^ {7'h0, vn, 1'b0}}, hv_q.size() == 1 ? hv_q[0] : 20'hx);
  endtask
  task automatic ls(logic w);
    ls_addr = 20'($random(seed));
    ls_wdata = 16'($random(seed));
    ls_wr = w;
    ls_valid = 1'b1;
    @(posedge clk);
    #1 ls_valid = 1'b0;
    idle();
    acc("ls", {~w, w, 1'b0}, ls_addr, ls_wdata, {16{w}});
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    rst(8);
    for (int i = 0; i < 8; i++) ex(cev_kind_t'(i), 3'h0, 8'h0, vt[i]);
    for (int i = 1; i < 8; i++) ex(CEV_EX_AUTO, 3'(i), 8'h0, 8'(8'h10 + i));
    ex(CEV_EX_USER, 3'h0, 8'h37, 8'h0f);
    ex(CEV_EX_USER, 3'h0, 8'h38, 8'h38);
    ex(CEV_EX_USER, 3'h0, 8'hff, 8'hff);
    for (int i = 0; i < 6; i++) ls(i[0]);
    rst(2);
    ex(CEV_EX_SWI, 3'h0, 8'h0, 8'h06);
    end_sim();
  end
  initial begin
    #100000;
    err_total++;
    end_sim();
  end
endmodule // testbench
